/* File: dcws_regs.svh */
`ifndef DCWS_REGS_SVH
`define DCWS_REGS_SVH

// ************************************************************
// Register word addresses
// ************************************************************
`define DCWS_A_CMD 5'h00
`define DCWS_A_PRIMARY_REFERENCE 5'h01
`define DCWS_A_SECONDARY_REFERENCE 5'h02
`define DCWS_A_CFG 5'h03
`define DCWS_A_PAR0 5'h04
`define DCWS_A_PARN 5'h14
`define DCWS_A_STAT 5'h15
`define DCWS_A_OUT1 5'h16
`define DCWS_A_OUT2 5'h17
`define DCWS_A_MOT 5'h18

// ************************************************************
// Limit and setting words, index from DCWS_A_PAR0
// ************************************************************
`define DCWS_NPAR 17
`define DCWS_P_R1MAX 5'h00
`define DCWS_P_R1MIN 5'h01
`define DCWS_P_R2MAX 5'h02
`define DCWS_P_R2MIN 5'h03
`define DCWS_P_SPMIN 5'h04
`define DCWS_P_SPMAX 5'h05
`define DCWS_P_FQMIN 5'h06
`define DCWS_P_FQMAX 5'h07
`define DCWS_P_T1MIN 5'h08
`define DCWS_P_T1MAX 5'h09
`define DCWS_P_T2MIN 5'h0A
`define DCWS_P_T2MAX 5'h0B
`define DCWS_P_P1MIN 5'h0C
`define DCWS_P_P1MAX 5'h0D
`define DCWS_P_P2MIN 5'h0E
`define DCWS_P_P2MAX 5'h0F
`define DCWS_P_RSTEP 5'h10

// ************************************************************
// Configuration and status fields
// ************************************************************
`define DCWS_CFG_W 10
`define DCWS_F_ALT 0
`define DCWS_F_R1SEL 1
`define DCWS_F_R2SEL 3
`define DCWS_F_R2TYP 5
`define DCWS_F_FREQ 7
`define DCWS_F_TQ2 8
`define DCWS_F_PID2 9
`define DCWS_F_EARLY 6

// ************************************************************
// Reset values, command codes, scaling
// ************************************************************
`define DCWS_RSTEP_RST 32'sh0000_0001
`define DCWS_CW_SW_ON 16'h0006
`define DCWS_CW_READY 16'h0007
`define DCWS_CW_ENABLE 16'h000F
`define DCWS_CW_RAMP 16'h002F
`define DCWS_CW_RUN 16'h006F
`define DCWS_STD1_FULL 32'sh0000_4E20
`define DCWS_STD2_FULL 32'sh0000_2710
`define DCWS_ALT_UNIT 32'sh0000_03E8
`define DCWS_AI_FULL 64'sh0000_0000_0000_2710
`define DCWS_AI_HALF 64'sh0000_0000_0000_1388
`define DCWS_REF_LIM 32'sh0000_7FFF
`define DCWS_SETTLE_MS 32'h0000_0064
`define DCWS_CLK_KHZ 32'h0000_4E20

`endif

/* File: dcws_pkg.sv */
package dcws_pkg;

   typedef enum logic [2:0] {
      DCWS_S_NRDY = 3'b000,
      DCWS_S_RDY_ON = 3'b001,
      DCWS_S_RDY_OP = 3'b010,
      DCWS_S_OP_EN = 3'b011,
      DCWS_S_ACC_EN = 3'b100,
      DCWS_S_RUN = 3'b101
   } dcws_state_t;

   typedef enum logic [1:0] {
      DCWS_SEL_BUS = 2'b00,
      DCWS_SEL_SUM = 2'b01,
      DCWS_SEL_PROD = 2'b10
   } dcws_sel_t;

   typedef enum logic [1:0] {
      DCWS_T_SPEED = 2'b00,
      DCWS_T_TORQUE = 2'b01,
      DCWS_T_PID = 2'b10
   } dcws_r2type_t;

endpackage

/* File: dcws_ref_if.sv */
`timescale 1ns/10ps
`default_nettype none

interface dcws_ref_if;
   logic signed [31:0] raw;
   logic alt;
   dcws_pkg::dcws_sel_t sel;
   logic [15:0] ai;
   logic signed [31:0] max;
   logic signed [31:0] val;

   modport scaler (input raw, input alt, input sel, input ai, input max, output val);
   modport user (output raw, output alt, output sel, output ai, output max, input val);
endinterface

`default_nettype wire

/* File: dcws_scaler.sv */
`timescale 1ns/10ps
`default_nettype none
`include "dcws_regs.svh"

module dcws_scaler #(
   parameter bit PRIMARY = 1'b1
) (
   dcws_ref_if.scaler rif
);

   logic signed [31:0] full;
   logic signed [31:0] raw16;
   logic signed [31:0] bus;
   logic signed [63:0] prod;
   logic signed [63:0] aip;
   logic signed [63:0] pp;

   always_comb begin
      full = PRIMARY ? `DCWS_STD1_FULL : `DCWS_STD2_FULL;
      raw16 = {{16{rif.raw[15]}}, rif.raw[15:0]};
      if (raw16 < -`DCWS_REF_LIM) begin
         raw16 = -`DCWS_REF_LIM;
      end
      prod = raw16 * rif.max;
      if (rif.alt) begin
         bus = rif.raw / `DCWS_ALT_UNIT;
      end else begin
         bus = 32'(prod / full);
      end
      aip = $signed({1'b0, rif.ai}) * rif.max;
      pp = bus * $signed({1'b0, rif.ai});
      case (rif.sel)
         dcws_pkg::DCWS_SEL_SUM: begin
            rif.val = bus + 32'(aip / `DCWS_AI_FULL) - (rif.max >>> 1);
         end
         dcws_pkg::DCWS_SEL_PROD: begin
            rif.val = 32'(pp / `DCWS_AI_HALF);
         end
         default: begin
            rif.val = bus;
         end
      endcase
   end

endmodule

`default_nettype wire

/* File: dcws_ramp.sv */
`timescale 1ns/10ps
`default_nettype none

module dcws_ramp (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic release_en,
   input wire logic accel_en,
   input wire logic signed [31:0] target,
   input wire logic signed [31:0] step,
   output logic signed [31:0] out
);

   logic signed [31:0] out_r;
   logic signed [31:0] goal;
   logic signed [32:0] diff;

   // Input held at zero until running
   always_comb begin
      goal = accel_en ? target : '0;
      diff = 33'(goal) - 33'(out_r);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         out_r <= '0;
      end else if (!release_en) begin
         out_r <= '0;
      // Zero or negative step jumps straight to the goal
      end else if (step <= 32'sh0000_0000) begin
         out_r <= goal;
      end else if (diff > step) begin
         out_r <= out_r + step;
      end else if (diff < -step) begin
         out_r <= out_r - step;
      end else begin
         out_r <= goal;
      end
   end

   assign out = out_r;

endmodule

`default_nettype wire

/* File: dcws_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "dcws_regs.svh"

module dcws_top #(
   parameter int unsigned SETTLE_CYC = `DCWS_SETTLE_MS * `DCWS_CLK_KHZ
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [4:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   input wire logic [15:0] analog_input_one,
   output logic [2:0] drive_state,
   output logic motor_run,
   output logic ramp_release,
   output logic ramp_accel,
   output logic early_command,
   output logic [31:0] primary_reference_out,
   output logic [31:0] secondary_reference_out,
   output logic [31:0] ramp_generator_out
);

   // ************************************************************
   // Helpers
   // ************************************************************
   function automatic dcws_pkg::dcws_state_t dcws_next(
      input dcws_pkg::dcws_state_t s,
      input logic [15:0] cw
   );
      dcws_pkg::dcws_state_t n;
      n = s;
      case (s)
         dcws_pkg::DCWS_S_NRDY: begin
            if (cw == `DCWS_CW_SW_ON) n = dcws_pkg::DCWS_S_RDY_ON;
         end
         dcws_pkg::DCWS_S_RDY_ON: begin
            if (cw == `DCWS_CW_READY) n = dcws_pkg::DCWS_S_RDY_OP;
         end
         dcws_pkg::DCWS_S_RDY_OP: begin
            if (cw == `DCWS_CW_ENABLE) n = dcws_pkg::DCWS_S_OP_EN;
         end
         dcws_pkg::DCWS_S_OP_EN: begin
            if (cw == `DCWS_CW_RAMP) n = dcws_pkg::DCWS_S_ACC_EN;
         end
         dcws_pkg::DCWS_S_ACC_EN: begin
            if (cw == `DCWS_CW_RUN) n = dcws_pkg::DCWS_S_RUN;
         end
         default: begin
            n = s;
         end
      endcase
      return n;
   endfunction

   function automatic logic signed [31:0] dcws_clamp(
      input logic signed [31:0] v,
      input logic signed [31:0] lo,
      input logic signed [31:0] hi
   );
      logic signed [31:0] r;
      r = v;
      if (v < lo) r = lo;
      if (v > hi) r = hi;
      return r;
   endfunction

   // Magnitude clamp keeps the direction sign of a bipolar reference
   function automatic logic signed [31:0] dcws_clamp_mag(
      input logic signed [31:0] v,
      input logic signed [31:0] lo,
      input logic signed [31:0] hi
   );
      logic signed [31:0] m;
      m = (v < 0) ? -v : v;
      m = dcws_clamp(m, lo, hi);
      return (v < 0) ? -m : m;
   endfunction

   // ************************************************************
   // Registers
   // ************************************************************
   logic [15:0] cw_r;
   logic signed [31:0] primary_reference_r;
   logic signed [31:0] secondary_reference_r;
   logic [`DCWS_CFG_W-1:0] cfg_r;
   logic signed [31:0] par_r [`DCWS_NPAR];
   dcws_pkg::dcws_state_t state_r;
   dcws_pkg::dcws_state_t state_nxt;
   logic early_r;
   logic [31:0] settle_r;
   logic signed [31:0] out1_r;
   logic signed [31:0] out2_r;
   logic [31:0] rdata_r;
   logic [31:0] rd_nxt;
   logic signed [31:0] fin1;
   logic signed [31:0] fin2;
   logic signed [31:0] mot_tgt;
   logic cmd_wr;
   logic par_hit;
   logic [4:0] par_idx;
   dcws_pkg::dcws_r2type_t r2type;

   assign cmd_wr = wr && (addr == `DCWS_A_CMD);
   assign par_hit = (addr >= `DCWS_A_PAR0) && (addr <= `DCWS_A_PARN);
   assign par_idx = addr - `DCWS_A_PAR0;
   assign r2type = dcws_pkg::dcws_r2type_t'(cfg_r[`DCWS_F_R2TYP +: 2]);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cw_r <= '0;
         primary_reference_r <= '0;
         secondary_reference_r <= '0;
         cfg_r <= '0;
      end else if (wr) begin
         case (addr)
            `DCWS_A_CMD: cw_r <= wdata[15:0];
            `DCWS_A_PRIMARY_REFERENCE: primary_reference_r <= wdata;
            `DCWS_A_SECONDARY_REFERENCE: secondary_reference_r <= wdata;
            `DCWS_A_CFG: cfg_r <= wdata[`DCWS_CFG_W-1:0];
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < `DCWS_NPAR; i++) begin
            par_r[i] <= (i == int'(`DCWS_P_RSTEP)) ? `DCWS_RSTEP_RST : '0;
         end
      end else if (wr && par_hit) begin
         par_r[par_idx] <= wdata;
      end
   end

   // ************************************************************
   // Drive state sequence
   // ************************************************************
   // unmatched word ignored
   assign state_nxt = cmd_wr ? dcws_next(state_r, wdata[15:0]) : state_r;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= dcws_pkg::DCWS_S_NRDY;
      end else begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         settle_r <= '0;
      end else if (state_nxt == dcws_pkg::DCWS_S_RDY_ON &&
                   state_r != dcws_pkg::DCWS_S_RDY_ON) begin
         settle_r <= SETTLE_CYC;
      end else if (settle_r != '0) begin
         settle_r <= settle_r - 32'h0000_0001;
      end
   end

   // Sticky flag, cleared by writing 1; a new event wins over the clear
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         early_r <= 1'b0;
      end else if (cmd_wr && state_r == dcws_pkg::DCWS_S_RDY_ON && settle_r != '0) begin
         early_r <= 1'b1;
      end else if (wr && addr == `DCWS_A_STAT && wdata[`DCWS_F_EARLY]) begin
         early_r <= 1'b0;
      end
   end

   assign drive_state = state_r;
   assign motor_run = (state_r == dcws_pkg::DCWS_S_OP_EN) ||
                      (state_r == dcws_pkg::DCWS_S_ACC_EN) ||
                      (state_r == dcws_pkg::DCWS_S_RUN);
   assign ramp_release = (state_r == dcws_pkg::DCWS_S_ACC_EN) ||
                         (state_r == dcws_pkg::DCWS_S_RUN);
   assign ramp_accel = (state_r == dcws_pkg::DCWS_S_RUN);
   assign early_command = early_r;

   // ************************************************************
   // Reference scaling and limits
   // ************************************************************
   dcws_ref_if r1_if ();
   dcws_ref_if r2_if ();

   assign r1_if.raw = primary_reference_r;
   assign r1_if.alt = cfg_r[`DCWS_F_ALT];
   assign r1_if.sel = dcws_pkg::dcws_sel_t'(cfg_r[`DCWS_F_R1SEL +: 2]);
   assign r1_if.ai = analog_input_one;
   assign r1_if.max = par_r[`DCWS_P_R1MAX];
   assign r2_if.raw = secondary_reference_r;
   assign r2_if.alt = cfg_r[`DCWS_F_ALT];
   assign r2_if.sel = dcws_pkg::dcws_sel_t'(cfg_r[`DCWS_F_R2SEL +: 2]);
   assign r2_if.ai = analog_input_one;
   assign r2_if.max = par_r[`DCWS_P_R2MAX];

   dcws_scaler #(.PRIMARY(1'b1)) u_scale1 (.rif(r1_if));
   dcws_scaler #(.PRIMARY(1'b0)) u_scale2 (.rif(r2_if));

   always_comb begin
      fin1 = dcws_clamp_mag(r1_if.val, par_r[`DCWS_P_R1MIN], par_r[`DCWS_P_R1MAX]);
      case (r2type)
         dcws_pkg::DCWS_T_TORQUE: begin
            if (cfg_r[`DCWS_F_TQ2]) begin
               fin2 = dcws_clamp(r2_if.val, par_r[`DCWS_P_T2MIN], par_r[`DCWS_P_T2MAX]);
            end else begin
               fin2 = dcws_clamp(r2_if.val, par_r[`DCWS_P_T1MIN], par_r[`DCWS_P_T1MAX]);
            end
         end
         dcws_pkg::DCWS_T_PID: begin
            if (cfg_r[`DCWS_F_PID2]) begin
               fin2 = dcws_clamp(r2_if.val, par_r[`DCWS_P_P2MIN], par_r[`DCWS_P_P2MAX]);
            end else begin
               fin2 = dcws_clamp(r2_if.val, par_r[`DCWS_P_P1MIN], par_r[`DCWS_P_P1MAX]);
            end
         end
         default: begin
            fin2 = dcws_clamp_mag(r2_if.val, par_r[`DCWS_P_R2MIN], par_r[`DCWS_P_R2MAX]);
         end
      endcase
      if (cfg_r[`DCWS_F_FREQ]) begin
         mot_tgt = dcws_clamp(out1_r, par_r[`DCWS_P_FQMIN], par_r[`DCWS_P_FQMAX]);
      end else begin
         mot_tgt = dcws_clamp(out1_r, par_r[`DCWS_P_SPMIN], par_r[`DCWS_P_SPMAX]);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         out1_r <= '0;
         out2_r <= '0;
      end else begin
         out1_r <= fin1;
         out2_r <= fin2;
      end
   end

   assign primary_reference_out = out1_r;
   assign secondary_reference_out = out2_r;

   dcws_ramp u_ramp (
      .clk(clk),
      .rst_n(rst_n),
      .release_en(ramp_release),
      .accel_en(ramp_accel),
      .target(mot_tgt),
      .step(par_r[`DCWS_P_RSTEP]),
      .out(ramp_generator_out)
   );

   // ************************************************************
   // Read port
   // ************************************************************
   always_comb begin
      rd_nxt = '0;
      case (addr)
         `DCWS_A_CMD: rd_nxt = {16'h0000, cw_r};
         `DCWS_A_PRIMARY_REFERENCE: rd_nxt = primary_reference_r;
         `DCWS_A_SECONDARY_REFERENCE: rd_nxt = secondary_reference_r;
         `DCWS_A_CFG: rd_nxt = {22'h00_0000, cfg_r};
         `DCWS_A_STAT: begin
            rd_nxt = {25'h000_0000, early_r, ramp_accel, ramp_release, motor_run,
                      state_r};
         end
         `DCWS_A_OUT1: rd_nxt = out1_r;
         `DCWS_A_OUT2: rd_nxt = out2_r;
         `DCWS_A_MOT: rd_nxt = ramp_generator_out;
         default: begin
            if (par_hit) rd_nxt = par_r[par_idx];
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_r <= '0;
      end else begin
         rdata_r <= rd ? rd_nxt : '0;
      end
   end

   assign rdata = rdata_r;

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking dcws_cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   logic signed [31:0] mx1;
   logic signed [31:0] mn1;
   logic signed [31:0] mx2;
   logic signed [31:0] mn2;
   assign mx1 = par_r[`DCWS_P_R1MAX];
   assign mn1 = par_r[`DCWS_P_R1MIN];
   assign mx2 = par_r[`DCWS_P_R2MAX];
   assign mn2 = par_r[`DCWS_P_R2MIN];

   AST_HOLD_NRDY: assert property (
      state_r == dcws_pkg::DCWS_S_NRDY && !(cmd_wr && wdata[15:0] == `DCWS_CW_SW_ON)
      |=> state_r == dcws_pkg::DCWS_S_NRDY)
      else $error("left not-ready without switch-on word");
   AST_SW_ON: assert property (
      state_r == dcws_pkg::DCWS_S_NRDY && cmd_wr && wdata[15:0] == `DCWS_CW_SW_ON
      |=> state_r == dcws_pkg::DCWS_S_RDY_ON && !motor_run)
      else $error("switch-on word not taken");
   AST_READY: assert property (
      state_r == dcws_pkg::DCWS_S_RDY_ON && cmd_wr && wdata[15:0] == `DCWS_CW_READY
      |=> state_r == dcws_pkg::DCWS_S_RDY_OP)
      else $error("ready word not taken");
   AST_ENABLE: assert property (
      state_r == dcws_pkg::DCWS_S_RDY_OP && cmd_wr && wdata[15:0] == `DCWS_CW_ENABLE
      |=> motor_run && !ramp_release ##1 ramp_generator_out == '0)
      else $error("enable word wrong or ramp moved");
   AST_RAMP_REL: assert property (
      state_r == dcws_pkg::DCWS_S_OP_EN && cmd_wr && wdata[15:0] == `DCWS_CW_RAMP
      |=> ramp_release && !ramp_accel)
      else $error("ramp release word not taken");
   AST_RUN: assert property (
      state_r == dcws_pkg::DCWS_S_ACC_EN && cmd_wr && wdata[15:0] == `DCWS_CW_RUN
      |=> state_r == dcws_pkg::DCWS_S_RUN && ramp_accel)
      else $error("run word not taken");
   AST_NO_MATCH: assert property (
      cmd_wr && dcws_next(state_r, wdata[15:0]) == state_r |=> $stable(state_r))
      else $error("state moved on unmatched word");
   AST_R1_FULL: assert property (
      !cfg_r[`DCWS_F_ALT] && cfg_r[`DCWS_F_R1SEL +: 2] == 2'h0 &&
      primary_reference_r[15:0] == 16'h4E20 && mn1 >= 0 && mn1 <= mx1 && !wr
      |=> out1_r == $past(mx1))
      else $error("primary full scale wrong");
   AST_R2_FULL: assert property (
      !cfg_r[`DCWS_F_ALT] && cfg_r[`DCWS_F_R2SEL +: 2] == 2'h0 &&
      r2type == dcws_pkg::DCWS_T_SPEED && secondary_reference_r[15:0] == 16'h2710 &&
      mn2 >= 0 && mn2 <= mx2 && !wr
      |=> out2_r == $past(mx2))
      else $error("secondary full scale wrong");
   AST_R1_CLAMP: assert property (
      mn1 >= 0 && mn1 <= mx1 && !wr
      |=> out1_r <= $past(mx1) && out1_r >= -$past(mx1))
      else $error("primary outside maximum");
   AST_MOT_LIM: assert property (
      !cfg_r[`DCWS_F_FREQ] && par_r[`DCWS_P_SPMIN] <= par_r[`DCWS_P_SPMAX]
      |-> mot_tgt >= par_r[`DCWS_P_SPMIN] && mot_tgt <= par_r[`DCWS_P_SPMAX])
      else $error("motor target outside speed limits");

   COV_RUN: cover property (state_r == dcws_pkg::DCWS_S_RUN);
   COV_REJECT: cover property (cmd_wr && dcws_next(state_r, wdata[15:0]) == state_r);
   COV_ALT_RUN: cover property (cfg_r[`DCWS_F_ALT] && ramp_accel);
   COV_EARLY: cover property ($rose(early_r));

endmodule

`default_nettype wire

/* File: dcws_ctl_model.sv */
`timescale 1ns/10ps
`default_nettype none

// ************************************************************
// Fieldbus controller: register master
// ************************************************************
module dcws_ctl_model #(
   parameter int unsigned SETTLE_CYC = 20
) (
   input wire logic clk,
   output logic [4:0] addr,
   output logic [31:0] wdata,
   output logic wr,
   output logic rd,
   input wire logic [31:0] rdata
);
   initial begin
      addr = 5'h00;
      wdata = 32'h0000_0000;
      wr = 1'b0;
      rd = 1'b0;
   end

   task wr_reg(input logic [4:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task rd_reg(input logic [4:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask

   task settle_wait;
      repeat (SETTLE_CYC + 1) @(posedge clk);
   endtask
endmodule

`default_nettype wire

/* File: drive_command_word_sequencer_test.sv */
`timescale 1ns/10ps
`default_nettype none
`include "dcws_regs.svh"

module drive_command_word_sequencer_test;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [15:0] ai = 16'h0000;
   logic [4:0] addr;
   logic [31:0] wdata, rdata, v, o1, o2, rg;
   logic wr, rd, run, rel, acc, early;
   logic [2:0] st;
   int bad_count = 0;
   int check_count = 0;
   int raw, a, m;
   int cfgs[5] = '{32'h20, 32'h120, 32'h40, 32'h240, 32'h20};
   int raws[5] = '{10000, 10000, 10000, 10000, -10000};
   int exps[5] = '{400, 200, 500, 300, -300};

   always #25 clk = ~clk;

   dcws_top #(.SETTLE_CYC(20)) uut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .analog_input_one(ai), .drive_state(st),
      .motor_run(run), .ramp_release(rel), .ramp_accel(acc), .early_command(early),
      .primary_reference_out(o1), .secondary_reference_out(o2), .ramp_generator_out(rg));

   dcws_ctl_model #(.SETTLE_CYC(20)) ctl (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata));

   task finish_test;
      $display("mismatches %0d checks %0d", bad_count, check_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task chk(input logic signed [31:0] got, input int e, input string what);
      check_count++;
      if (got !== e) begin
         bad_count++;
         $display("mismatch %0t %s got %0d exp %0d", $time, what, got, e);
      end
   endtask

   function int clampm(int x, int lo, int hi);
      int k;
      k = (x < 0) ? -x : x;
      if (k > hi) k = hi;
      if (k < lo) k = lo;
      return (x < 0) ? -k : k;
   endfunction

   // Primary model: mode 0 bus, 1 sum, 2 product
   function int p1(int mode, int r, int an);
      int b;
      b = r * 1500 / 20000;
      if (mode == 1) b = b + an * 1500 / 10000 - 750;
      if (mode == 2) b = b * an / 5000;
      return clampm(b, 100, 1500);
   endfunction

   task cmd(input logic [15:0] w, input int e);
      ctl.wr_reg(`DCWS_A_CMD, {16'h0000, w});
      #1 chk(st, e, "state");
   endtask

   task setp(input logic [4:0] i, input int d);
      ctl.wr_reg(`DCWS_A_PAR0 + i, d);
   endtask

   task settle;
      repeat (3) @(posedge clk);
      #1;
   endtask

   task wait_ramp(input int e);
      int n;
      n = 0;
      while ($signed(rg) !== e && n < 200) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk(rg, e, "ramp");
   endtask

   initial begin
      #(50 * 20000);
      bad_count++;
      $display("mismatch %0t watchdog expired", $time);
      finish_test();
   end

   initial begin
      void'($urandom(17452));
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      #1 chk(st, 0, "reset state");
      setp(`DCWS_P_R1MAX, 1500);
      setp(`DCWS_P_R2MAX, 800);
      setp(`DCWS_P_SPMIN, -1000);
      setp(`DCWS_P_SPMAX, 1000);
      setp(`DCWS_P_FQMIN, -700);
      setp(`DCWS_P_FQMAX, 700);
      setp(`DCWS_P_T1MIN, -300);
      setp(`DCWS_P_T1MAX, 400);
      setp(`DCWS_P_T2MIN, -300);
      setp(`DCWS_P_T2MAX, 200);
      setp(`DCWS_P_P1MAX, 500);
      setp(`DCWS_P_P2MAX, 300);
      setp(`DCWS_P_RSTEP, 256);
      cmd(16'h000F, 0);
      cmd(16'h0006, 1);
      ctl.settle_wait();
      cmd(16'h0007, 2);
      chk(early, 0, "early flag");
      cmd(16'h002F, 2);
      cmd(16'h000F, 3);
      chk({run, rel}, 2, "run no release");
      cmd(16'h002F, 4);
      chk({rel, acc}, 2, "release no accel");
      cmd(16'h006F, 5);
      ctl.rd_reg(`DCWS_A_STAT, v);
      chk(v, 32'h3D, "status");
      ctl.rd_reg(5'h1F, v);
      chk(v, 0, "unmapped");
      for (int i = 0; i < 20; i++) begin
         raw = $urandom_range(65534) - 32767;
         ctl.wr_reg(`DCWS_A_PRIMARY_REFERENCE, raw);
         ctl.wr_reg(`DCWS_A_SECONDARY_REFERENCE, raw);
         settle();
         chk(o1, clampm(raw * 1500 / 20000, 0, 1500), "primary_reference");
         chk(o2, clampm(raw * 800 / 10000, 0, 800), "secondary_reference");
      end
      setp(`DCWS_P_R1MIN, 100);
      foreach (raws[i]) begin
         ctl.wr_reg(`DCWS_A_PRIMARY_REFERENCE, (i == 4) ? 1000 : 2000 * (i + 1));
         settle();
         chk(o1, p1(0, (i == 4) ? 1000 : 2000 * (i + 1), 0), "min");
      end
      ctl.wr_reg(`DCWS_A_PRIMARY_REFERENCE, 32'h7FFF);
      settle();
      chk(o1, 1500, "clamp");
      wait_ramp(1000);
      ctl.wr_reg(`DCWS_A_CFG, 32'h80);
      wait_ramp(700);
      foreach (cfgs[i]) begin
         ctl.wr_reg(`DCWS_A_CFG, cfgs[i]);
         ctl.wr_reg(`DCWS_A_SECONDARY_REFERENCE, raws[i]);
         settle();
         chk(o2, exps[i], "secondary_reference limit");
      end
      ctl.wr_reg(`DCWS_A_CFG, 32'h01);
      ctl.wr_reg(`DCWS_A_PRIMARY_REFERENCE, 1234567);
      ctl.wr_reg(`DCWS_A_SECONDARY_REFERENCE, -654321);
      settle();
      chk(o1, 1234, "alt primary_reference");
      chk(o2, -654, "alt secondary_reference");
      for (int i = 0; i < 16; i++) begin
         m = (i < 8) ? 1 : 2;
         raw = $urandom_range(20000);
         a = $urandom_range(10000);
         @(posedge clk);
         ai <= 16'(a);
         ctl.wr_reg(`DCWS_A_CFG, m * 2);
         ctl.wr_reg(`DCWS_A_PRIMARY_REFERENCE, raw);
         settle();
         chk(o1, p1(m, raw, a), "analog mix");
      end
      setp(`DCWS_P_RSTEP, 0);
      ctl.wr_reg(`DCWS_A_CFG, 32'h00);
      ctl.wr_reg(`DCWS_A_PRIMARY_REFERENCE, 32'h0000_4E20);
      ctl.wr_reg(`DCWS_A_SECONDARY_REFERENCE, 32'h0000_2710);
      settle();
      chk(o1, 1500, "full scale 1");
      chk(o2, 800, "full scale 2");
      ctl.wr_reg(`DCWS_A_PRIMARY_REFERENCE, 32'h0000_B1E0);
      settle();
      chk(o1, -1500, "16-bit negative");
      chk(rg, -1000, "ramp jump");
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      #1 chk(st, 0, "second reset");
      chk(rg, 0, "reset ramp");
      cmd(16'h0006, 1);
      cmd(16'h0007, 2);
      chk(early, 1, "early flag set");
      ctl.wr_reg(`DCWS_A_STAT, 32'h40);
      #1 chk(early, 0, "early flag clear");
      finish_test();
   end
endmodule

`default_nettype wire
